//--- src/adcclk_regs.vh
// Register offsets, field positions, reset values and timing constants of the converter clock control
`ifndef ADCCLK_REGS_VH
`define ADCCLK_REGS_VH

// ***************************************
// Register map
// ***************************************
`define ADCCLK_ADDR_W           4
`define ADCCLK_OFF_TIMING       4'h0
`define ADCCLK_OFF_CTRL_TWO     4'h1
`define ADCCLK_OFF_CTRL         4'h2
`define ADCCLK_OFF_RESULT_RAW   4'h3
`define ADCCLK_OFF_RESULT_UNS   4'h4
`define ADCCLK_OFF_RESULT_SGN   4'h5
`define ADCCLK_OFF_STATUS       4'h6

// ***************************************
// Field positions
// ***************************************
`define ADCCLK_BIT_CLK_SRC      15
`define ADCCLK_BIT_EXT_SAMPLE_CONTROL     14
`define ADCCLK_BIT_RSVD         13
`define ADCCLK_AUTO_SAMPLE_PERIODS_HI          12
`define ADCCLK_AUTO_SAMPLE_PERIODS_LO          8
`define ADCCLK_DIV_HI           7
`define ADCCLK_DIV_LO           0
`define ADCCLK_BIT_ALT          0
`define ADCCLK_BIT_SPLIT        1
`define ADCCLK_BIT_REGBUF       2
`define ADCCLK_BIT_SAMPLE       0
`define ADCCLK_BIT_AUTO         1
`define ADCCLK_BIT_SIGNED       2

// ***************************************
// Reset values and limits
// ***************************************
`define ADCCLK_RST_TIMING       16'h0000
`define ADCCLK_RST_CTRL_TWO     3'h0
`define ADCCLK_RST_CTRL         3'h0
`define ADCCLK_DIV_MAX          8'h3F
`define ADCCLK_CONV_PERIODS     5'h0C

`endif

//--- src/adcclk_divider.v
// Conversion period divider producing one-cycle period enables
`timescale 1ns/1ps
module adcclk_divider (
    input  wire       clk,
    input  wire       rst,
    input  wire       run,
    input  wire [7:0] divide,
    input  wire       tick_in,
    output wire       period_en
);
    reg  [7:0] cnt_ff;
    reg  [7:0] nxt_cnt;

    // Restart keeps the first period whole after sampling begins
    always @* begin
        nxt_cnt = cnt_ff;
        if (!run)
            nxt_cnt = 8'h00;
        else if (tick_in)
            nxt_cnt = (cnt_ff >= divide) ? 8'h00 : cnt_ff + 8'h01;
    end

    always @(posedge clk or posedge rst) begin
        if (rst)
            cnt_ff <= 8'h00;
        else
            cnt_ff <= nxt_cnt;
    end

    assign period_en = run && tick_in && (cnt_ff >= divide);
endmodule // adcclk_divider

//--- src/adcclk_ctrl.v
// Converter clock, sampling sequence and result format control
`timescale 1ns/1ps
`include "adcclk_regs.vh"
module adcclk_ctrl (
    input  wire        clk,
    input  wire        rst,
    input  wire [3:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    input  wire        rc_clk_pin,
    input  wire        cycle_tick,
    input  wire        result_valid,
    input  wire [10:0] result_code,
    input  wire        fill_half_in,
    output reg  [15:0] rdata,
    output reg         sampling,
    output reg         conv_start,
    output reg         use_set_b,
    output reg         rc_clock_selected,
    output reg         fill_half
);
    // ***************************************
    // State
    // ***************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SAMPLE_CONTROL = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;

    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg         clk_src_ff;
    reg  [4:0]  auto_sample_periods_ff;
    reg  [7:0]  div_ff;
    reg         alt_ff;
    reg         split_ff;
    reg         regbuf_ff;
    reg         sample_ff;
    reg         auto_ff;
    reg         signed_ff;
    reg  [4:0]  sample_control_cnt_ff;
    reg  [3:0]  conv_cnt_ff;
    reg         set_b_ff;
    reg  [10:0] raw_ff;
    reg  [15:0] uns_ff;
    reg  [15:0] sgn_ff;
    reg         rc_meta_ff;
    reg         rc_sync_ff;
    reg         rc_prev_ff;
    wire        period_en;
    wire        period_tick;
    wire        wr_timing;
    wire        wr_ctrl;
    wire        sample_control_done;
    wire        conv_done;

    function hit;
        input [3:0] a;
        input [3:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    assign wr_timing = wr_en && hit(addr, `ADCCLK_OFF_TIMING);
    assign wr_ctrl   = wr_en && hit(addr, `ADCCLK_OFF_CTRL);

    // ***************************************
    // Clock source
    // ***************************************
    // RC pin is asynchronous, so only its synchronised rising edges count
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_meta_ff <= 1'b0;
            rc_sync_ff <= 1'b0;
            rc_prev_ff <= 1'b0;
        end else begin
            rc_meta_ff <= rc_clk_pin;
            rc_sync_ff <= rc_meta_ff;
            rc_prev_ff <= rc_sync_ff;
        end
    end

    // RC source skips the divider; system source divides instruction cycles
    assign period_tick = clk_src_ff ? (rc_sync_ff && !rc_prev_ff) : period_en;

    adcclk_divider u_div (
        .clk       (clk),
        .rst       (rst),
        .run       (!clk_src_ff && (state_ff != ST_IDLE)),
        .divide    (div_ff),
        .tick_in   (cycle_tick),
        .period_en (period_en)
    );

    // ***************************************
    // Registers
    // ***************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_src_ff <= 1'b0;
            auto_sample_periods_ff    <= 5'h00;
            div_ff     <= 8'h00;
            alt_ff     <= 1'b0;
            split_ff   <= 1'b0;
            regbuf_ff  <= 1'b0;
            sample_ff  <= 1'b0;
            auto_ff    <= 1'b0;
            signed_ff  <= 1'b0;
        end else begin
            if (wr_timing) begin
                clk_src_ff <= wdata[`ADCCLK_BIT_CLK_SRC];
                auto_sample_periods_ff    <= wdata[`ADCCLK_AUTO_SAMPLE_PERIODS_HI:`ADCCLK_AUTO_SAMPLE_PERIODS_LO];
                // Reserved divider codes are clamped to the longest legal period
                div_ff     <= (wdata[`ADCCLK_DIV_HI:`ADCCLK_DIV_LO] > `ADCCLK_DIV_MAX) ?
                              `ADCCLK_DIV_MAX : wdata[`ADCCLK_DIV_HI:`ADCCLK_DIV_LO];
            end
            if (wr_en && hit(addr, `ADCCLK_OFF_CTRL_TWO)) begin
                alt_ff    <= wdata[`ADCCLK_BIT_ALT];
                split_ff  <= wdata[`ADCCLK_BIT_SPLIT];
                regbuf_ff <= wdata[`ADCCLK_BIT_REGBUF];
            end
            if (wr_ctrl) begin
                auto_ff   <= wdata[`ADCCLK_BIT_AUTO];
                signed_ff <= wdata[`ADCCLK_BIT_SIGNED];
            end
            // Auto mode ends sampling itself; a manual write wins over the auto clear
            if (wr_ctrl)
                sample_ff <= wdata[`ADCCLK_BIT_SAMPLE];
            else if (sample_control_done)
                sample_ff <= 1'b0;
        end
    end

    // ***************************************
    // Sampling sequence
    // ***************************************
    // Zero count ends at once; otherwise the tick that completes the count ends sampling
    assign sample_control_done = (state_ff == ST_SAMPLE_CONTROL) && auto_ff &&
                       ((auto_sample_periods_ff == 5'h00) || (period_tick && (sample_control_cnt_ff >= auto_sample_periods_ff - 5'h01)));
    assign conv_done = (state_ff == ST_CONV) && period_tick &&
                       ({1'b0, conv_cnt_ff} == `ADCCLK_CONV_PERIODS - 5'h01);

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (sample_ff) nxt_state = ST_SAMPLE_CONTROL;
            ST_SAMPLE_CONTROL: begin
                if (sample_control_done)
                    nxt_state = ST_CONV;
                else if (!auto_ff && !sample_ff)
                    nxt_state = ST_CONV;
            end
            ST_CONV: if (conv_done) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff    <= ST_IDLE;
            sample_control_cnt_ff <= 5'h00;
            conv_cnt_ff <= 4'h0;
            set_b_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff != ST_SAMPLE_CONTROL)
                sample_control_cnt_ff <= 5'h00;
            else if (period_tick && sample_control_cnt_ff != 5'h1F)
                sample_control_cnt_ff <= sample_control_cnt_ff + 5'h01;
            if (state_ff != ST_CONV)
                conv_cnt_ff <= 4'h0;
            else if (period_tick)
                conv_cnt_ff <= conv_cnt_ff + 4'h1;
            if (!alt_ff)
                set_b_ff <= 1'b0;
            else if (conv_done)
                set_b_ff <= ~set_b_ff;
        end
    end

    // ***************************************
    // Outputs and result formats
    // ***************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sampling          <= 1'b0;
            conv_start        <= 1'b0;
            use_set_b         <= 1'b0;
            rc_clock_selected <= 1'b0;
            fill_half         <= 1'b0;
            raw_ff            <= 11'h000;
            uns_ff            <= 16'h0000;
            sgn_ff            <= 16'h0000;
        end else begin
            sampling          <= (nxt_state == ST_SAMPLE_CONTROL);
            conv_start        <= (state_ff == ST_SAMPLE_CONTROL) && (nxt_state == ST_CONV);
            use_set_b         <= set_b_ff;
            rc_clock_selected <= clk_src_ff;
            fill_half         <= fill_half_in && split_ff && !regbuf_ff;
            if (result_valid) begin
                raw_ff <= result_code;
                uns_ff <= result_code[10] ? 16'h0000 : {result_code[9:0], 6'h00};
                sgn_ff <= {result_code[10], result_code[9:0], 5'h00};
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst)
            rdata <= 16'h0000;
        else if (rd_en) begin
            case (addr)
                `ADCCLK_OFF_TIMING:     rdata <= {clk_src_ff, sample_ext(state_ff, sample_ff), 1'b0,
                                                  auto_sample_periods_ff, div_ff};
                `ADCCLK_OFF_CTRL_TWO:   rdata <= {13'h0000, regbuf_ff, split_ff, alt_ff};
                `ADCCLK_OFF_CTRL:       rdata <= {13'h0000, signed_ff, auto_ff, sample_ff};
                `ADCCLK_OFF_RESULT_RAW: rdata <= {5'h00, raw_ff};
                `ADCCLK_OFF_RESULT_UNS: rdata <= signed_ff ? sgn_ff : uns_ff;
                `ADCCLK_OFF_RESULT_SGN: rdata <= sgn_ff;
                `ADCCLK_OFF_STATUS:     rdata <= {11'h000, fill_half, set_b_ff, state_ff};
                default:                rdata <= 16'h0000;
            endcase
        end else
            rdata <= 16'h0000;
    end

    // Still sampling though software has dropped sample control
    function sample_ext;
        input [2:0] st;
        input       smp;
        begin
            sample_ext = (st == ST_SAMPLE_CONTROL) && !smp;
        end
    endfunction
endmodule // adcclk_ctrl

//--- testbench/adcclk_chk.sv
// Port assertions for the converter clock control
`timescale 1ns/1ps
module adcclk_chk (
    input wire        clk,
    input wire        rst,
    input wire [3:0]  addr,
    input wire [15:0] wdata,
    input wire        wr_en,
    input wire        rd_en,
    input wire        fill_half_in,
    input wire [15:0] rdata,
    input wire        sampling,
    input wire        conv_start,
    input wire        use_set_b,
    input wire        rc_clock_selected,
    input wire        fill_half
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Sampling window closes
    sequence s_end; sampling ##1 !sampling; endsequence
    property p_src; wr_en && addr == 4'h0 && wdata[15] |-> ##[1:2] rc_clock_selected; endproperty
    property p_ext; $past(rd_en) && $past(addr) == 4'h0 && !$past(sampling) |-> !rdata[14]; endproperty
    property p_pulse; conv_start |=> !conv_start; endproperty
    property p_start; s_end |-> (conv_start || $past(conv_start)) or ##1 conv_start; endproperty
    property p_alt; $changed(use_set_b) |-> !sampling; endproperty
    property p_fill; fill_half |-> $past(fill_half_in); endproperty
    property p_sgn; $past(rd_en) && $past(addr) == 4'h5 |-> rdata[4:0] == 5'h00; endproperty
    property p_quiet; !$past(rd_en) |-> rdata == 16'h0000; endproperty
    a_src: assert property (p_src) else $error("clock source flag missed");
    a_ext: assert property (p_ext) else $error("extended flag while idle");
    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    a_start: assert property (p_start) else $error("sampling ended without start");
    a_alt: assert property (p_alt) else $error("input set changed mid sample");
    a_fill: assert property (p_fill) else $error("fill flag without input");
    a_sgn: assert property (p_sgn) else $error("signed result not justified");
    a_quiet: assert property (p_quiet) else $error("read data outside read slot");
endmodule // adcclk_chk
bind adcclk_ctrl adcclk_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .fill_half_in(fill_half_in), .rdata(rdata), .sampling(sampling), .conv_start(conv_start),
    .use_set_b(use_set_b), .rc_clock_selected(rc_clock_selected), .fill_half(fill_half));

//--- testbench/adc_sample_clock_control_tb.sv
// Self-checking bench for the converter clock control
`timescale 1ns/1ps
module adc_sample_clock_control_tb;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg  [15:0] wdata = 16'h0000;
    reg         wr_en = 1'b0;
    reg         rd_en = 1'b0;
    reg         rc_clk_pin = 1'b0;
    reg         result_valid = 1'b0;
    reg  [10:0] result_code = 11'h000;
    reg         fill_half_in = 1'b1;
    reg  [15:0] rv;
    wire [15:0] rdata;
    wire        sampling, conv_start, use_set_b, rc_sel, fill_half;
    integer     err_total = 0;
    integer     num_checks = 0;
    integer     n0, n1, n2, n3, i;
    always #12.5 clk = ~clk;
    // RC pin runs free at eight clocks a period, edges never on a rising clock edge
    always #100 rc_clk_pin = ~rc_clk_pin;
    adcclk_ctrl uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rc_clk_pin(rc_clk_pin), .cycle_tick(1'b1), .result_valid(result_valid), .result_code(result_code),
        .fill_half_in(fill_half_in), .rdata(rdata), .sampling(sampling), .conv_start(conv_start),
        .use_set_b(use_set_b), .rc_clock_selected(rc_sel), .fill_half(fill_half));
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input [15:0] seen, input [15:0] exp, input [63:0] nm);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr_en <= 1'b1;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask
    task rdchk(input [3:0] a, input [15:0] exp, input [63:0] nm);
        begin
            @(posedge clk);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            #1;
            chk(rdata, exp, nm);
        end
    endtask
    // Sampling length in clocks for one auto sample
    task run(input [15:0] t, output integer len);
        integer k;
        begin
            wr(4'h0, t);
            wr(4'h2, 16'h0003);
            len = 0;
            for (k = 0; k < 600 && (len == 0 || sampling); k = k + 1) begin
                @(posedge clk);
                #1;
                if (sampling) len = len + 1;
            end
            repeat (120) @(posedge clk);
        end
    endtask
    task res(input [10:0] c, input [15:0] u, input [15:0] s);
        begin
            @(posedge clk);
            result_valid <= 1'b1;
            result_code <= c;
            @(posedge clk);
            result_valid <= 1'b0;
            rdchk(4'h4, u, "unsigned");
            rdchk(4'h5, s, "signed");
        end
    endtask
    task conclude;
        begin
            $display("Checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(4'h0, 16'h0000, "timing");
        rdchk(4'h1, 16'h0000, "ctrl2");
        rdchk(4'hF, 16'h0000, "unmapped");
        wr(4'h0, 16'hDF3F);
        rdchk(4'h0, 16'h9F3F, "timing");
        chk({15'h0000, rc_sel}, 16'h0001, "rc_sel");
        run(16'h0201, n0);
        chk({15'h0000, rc_sel}, 16'h0000, "rc_sel");
        run(16'h0401, n1);
        run(16'h0203, n2);
        run(16'h0403, n3);
        chk(16'(n1 - n0), 16'h0004, "sample_control_len");
        chk(16'(n3 - n2), 16'h0008, "period");
        chk(16'(n0), 16'h0004, "sample_control_abs");
        chk(16'(n2), 16'h0008, "div_abs");
        run(16'h8301, n0);
        chk({15'h0000, (n0 >= 17 && n0 <= 24)}, 16'h0001, "rc_len");
        chk({15'h0000, use_set_b}, 16'h0000, "set_b");
        wr(4'h1, 16'h0001);
        for (i = 0; i < 3; i = i + 1) begin
            run(16'h0201, n0);
            chk({15'h0000, use_set_b}, (i % 2 == 0) ? 16'h0001 : 16'h0000, "set_b");
        end
        wr(4'h1, 16'h0000);
        run(16'h0201, n0);
        chk({15'h0000, use_set_b}, 16'h0000, "set_b");
        for (i = 0; i < 4; i = i + 1) begin
            wr(4'h1, 16'(i * 2));
            repeat (2) @(posedge clk);
            chk({15'h0000, fill_half}, (i == 1) ? 16'h0001 : 16'h0000, "fill");
        end
        wr(4'h1, 16'h0002);
        fill_half_in <= 1'b0;
        repeat (2) @(posedge clk);
        chk({15'h0000, fill_half}, 16'h0000, "fill_in");
        wr(4'h0, 16'h1F03);
        wr(4'h2, 16'h0003);
        wr(4'h2, 16'h0002);
        rdchk(4'h0, 16'h5F03, "ext_on");
        repeat (200) @(posedge clk);
        rdchk(4'h0, 16'h1F03, "ext_off");
        res(11'h3FF, 16'hFFC0, 16'h7FE0);
        res(11'h7FF, 16'h0000, 16'hFFE0);
        res(11'h400, 16'h0000, 16'h8000);
        res(11'h001, 16'h0040, 16'h0020);
        rdchk(4'h3, 16'h0001, "raw");
        wr(4'h2, 16'h0004);
        rdchk(4'h4, 16'h0020, "fmt_sel");
        conclude;
    end
    initial begin
        #300000;
        err_total = err_total + 1;
        conclude;
    end
endmodule // adc_sample_clock_control_tb
